// ---- core/chan_div.sv ----
//******************************************************************************
// Purpose: Divider 2 and divider 3 channel clock dividers with config registers
// Assumes: One divider input cycle per CLK cycle; DIV_IN is the input level
// Notes:   Bypass outputs DIV_IN delayed by one flop
//******************************************************************************
`timescale 1ns/10ps
module chan_div #(
   parameter int NCH = chan_div_pkg::NCH
) (
   // Clock and reset
   input  wire logic                             CLK,
   input  wire logic                             SRST,
   // Register port
   input  wire logic [chan_div_pkg::AW-1:0]      REG_ADDR,
   input  wire logic                             REG_WE,
   input  wire logic [chan_div_pkg::DW-1:0]      REG_WDATA,
   output logic      [chan_div_pkg::DW-1:0]      REG_RDATA,
   // Clock path
   input  wire logic                             DIV_IN,
   input  wire logic                             SYNC_REQ,
   output logic      [NCH-1:0]                   DIV_OUT,
   // Driver control
   output logic      [NCH*chan_div_pkg::PAIRS-1:0] DRV_PD,
   output logic      [NCH-1:0]                   DUTY_FIX_DIS
);

   //***************************************************************************
   // Elaboration checks
   //***************************************************************************
   if (NCH != chan_div_pkg::NCH) begin : g_bad_nch
      $error("NCH must match the register map");
   end
   if (NCH < 1) begin : g_bad_min
      $error("NCH must be at least one");
   end
   if (chan_div_pkg::PAIRS < 1) begin : g_bad_pairs
      $error("PAIRS must be at least one");
   end
   if (chan_div_pkg::HIGH_LSB + chan_div_pkg::CNT_W > chan_div_pkg::LOW_LSB) begin : g_bad_high
      $error("High-count field overlaps the low-count field");
   end
   if (chan_div_pkg::LOW_LSB + chan_div_pkg::CNT_W > chan_div_pkg::DW) begin : g_bad_low
      $error("Low-count field does not fit the data width");
   end
   if (chan_div_pkg::PH_LSB + chan_div_pkg::CNT_W > chan_div_pkg::STH_BIT) begin : g_bad_phase
      $error("Phase field overlaps the start-level bit");
   end
   if (chan_div_pkg::BYP_BIT >= chan_div_pkg::DW) begin : g_bad_byp
      $error("Bypass bit outside the data width");
   end
   if (chan_div_pkg::IGN_BIT >= chan_div_pkg::DW) begin : g_bad_ign
      $error("Ignore-sync bit outside the data width");
   end
   if (chan_div_pkg::FRC_BIT >= chan_div_pkg::DW) begin : g_bad_frc
      $error("Force bit outside the data width");
   end
   if (chan_div_pkg::STH_BIT >= chan_div_pkg::DW) begin : g_bad_sth
      $error("Start-level bit outside the data width");
   end
   if (chan_div_pkg::PD_BIT >= chan_div_pkg::DW) begin : g_bad_pd
      $error("Power-down bit outside the data width");
   end
   if (chan_div_pkg::DUTY_BIT >= chan_div_pkg::DW) begin : g_bad_duty
      $error("Duty fix bit outside the data width");
   end
   if (chan_div_pkg::PD_BIT == chan_div_pkg::DUTY_BIT) begin : g_bad_pwr
      $error("Power-down and duty fix bits must differ");
   end
   if ($bits(chan_div_pkg::PH_RST) != chan_div_pkg::CNT_W) begin : g_bad_phrst
      $error("Phase reset value width must match the count width");
   end

   typedef logic [chan_div_pkg::CNT_W-1:0] cnt_t;

   typedef struct packed {
      // Configuration
      logic [NCH-1:0][chan_div_pkg::DW-1:0]    cnt_cfg;
      logic [NCH-1:0]                          byp;
      logic [NCH-1:0]                          ign;
      logic [NCH-1:0]                          frc;
      logic [NCH-1:0]                          st_hi;
      logic [NCH-1:0][chan_div_pkg::CNT_W-1:0] phase;
      logic [NCH-1:0]                          pd;
      logic [NCH-1:0]                          duty_dis;
      // Divider state
      logic [NCH-1:0]                          lvl;
      logic [NCH-1:0]                          hold;
      logic [NCH-1:0][chan_div_pkg::CNT_W-1:0] ph_cnt;
      logic [NCH-1:0][chan_div_pkg::CNT_W-1:0] cnt;
      logic [NCH-1:0]                          out;
      // Read data
      logic [chan_div_pkg::DW-1:0]             rdata;
   } state_t;

   state_t         s_q;
   state_t         s_d;

   logic [NCH-1:0] cnt_hit;
   logic [NCH-1:0] mode_hit;
   logic [NCH-1:0] pwr_hit;
   logic [NCH-1:0] sync_obey;
   logic [NCH-1:0] sync_force;

   //***************************************************************************
   // Next state
   //***************************************************************************
   always_comb begin
      cnt_t lim;
      s_d = s_q;
      lim = chan_div_pkg::CNT_ZERO;
      s_d.rdata = '0;

      //************************************************************************
      // Register writes
      //************************************************************************
      for (int c = 0; c < NCH; c++) begin
         if (REG_WE && cnt_hit[c]) begin
            s_d.cnt_cfg[c] = REG_WDATA;
         end
         if (REG_WE && mode_hit[c]) begin
            s_d.byp[c]   = REG_WDATA[chan_div_pkg::BYP_BIT];
            s_d.ign[c]   = REG_WDATA[chan_div_pkg::IGN_BIT];
            s_d.frc[c]   = REG_WDATA[chan_div_pkg::FRC_BIT];
            s_d.st_hi[c] = REG_WDATA[chan_div_pkg::STH_BIT];
            s_d.phase[c] = REG_WDATA[chan_div_pkg::PH_LSB +: chan_div_pkg::CNT_W];
         end
         if (REG_WE && pwr_hit[c]) begin
            s_d.pd[c]       = REG_WDATA[chan_div_pkg::PD_BIT];
            s_d.duty_dis[c] = REG_WDATA[chan_div_pkg::DUTY_BIT];
         end
      end

      //************************************************************************
      // Register reads, reserved bits zero
      //************************************************************************
      for (int c = 0; c < NCH; c++) begin
         if (cnt_hit[c]) begin
            s_d.rdata = s_q.cnt_cfg[c];
         end
         if (mode_hit[c]) begin
            s_d.rdata[chan_div_pkg::BYP_BIT]                     = s_q.byp[c];
            s_d.rdata[chan_div_pkg::IGN_BIT]                     = s_q.ign[c];
            s_d.rdata[chan_div_pkg::FRC_BIT]                     = s_q.frc[c];
            s_d.rdata[chan_div_pkg::STH_BIT]                     = s_q.st_hi[c];
            s_d.rdata[chan_div_pkg::PH_LSB +: chan_div_pkg::CNT_W] = s_q.phase[c];
         end
         if (pwr_hit[c]) begin
            s_d.rdata[chan_div_pkg::PD_BIT]   = s_q.pd[c];
            s_d.rdata[chan_div_pkg::DUTY_BIT] = s_q.duty_dis[c];
         end
      end

      //************************************************************************
      // Divider core
      //************************************************************************
      for (int c = 0; c < NCH; c++) begin
         if (s_q.lvl[c]) begin
            lim = s_q.cnt_cfg[c][chan_div_pkg::HIGH_LSB +: chan_div_pkg::CNT_W];
         end else begin
            lim = s_q.cnt_cfg[c][chan_div_pkg::LOW_LSB +: chan_div_pkg::CNT_W];
         end
         if (sync_obey[c]) begin
            s_d.lvl[c]    = s_q.st_hi[c];
            s_d.cnt[c]    = chan_div_pkg::CNT_ZERO;
            s_d.hold[c]   = 1'b1;
            s_d.ph_cnt[c] = s_q.phase[c];
         end else if (s_q.hold[c]) begin
            if (s_q.ph_cnt[c] == chan_div_pkg::CNT_ZERO) begin
               s_d.hold[c] = 1'b0;
            end else begin
               s_d.ph_cnt[c] = s_q.ph_cnt[c] - chan_div_pkg::CNT_ONE;
            end
         end else if (s_q.cnt[c] == lim) begin
            s_d.lvl[c] = !s_q.lvl[c];
            s_d.cnt[c] = chan_div_pkg::CNT_ZERO;
         end else begin
            s_d.cnt[c] = s_q.cnt[c] + chan_div_pkg::CNT_ONE;
         end
      end

      //************************************************************************
      // Output select
      //************************************************************************
      for (int c = 0; c < NCH; c++) begin
         if (s_q.byp[c]) begin
            s_d.out[c] = DIV_IN;
         end else if (sync_force[c]) begin
            s_d.out[c] = s_q.frc[c];
         end else begin
            s_d.out[c] = s_d.lvl[c];
         end
      end
   end

   //***************************************************************************
   // State register
   //***************************************************************************
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_q <= '0;
         for (int c = 0; c < NCH; c++) begin
            s_q.cnt_cfg[c] <= chan_div_pkg::CNT_RST[c];
            s_q.phase[c]   <= chan_div_pkg::PH_RST;
         end
      end else begin
         s_q <= s_d;
      end
   end

   //***************************************************************************
   // Outputs
   //***************************************************************************
   assign REG_RDATA = s_q.rdata;
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      // Decode
      assign cnt_hit[g]    = (REG_ADDR == chan_div_pkg::CNT_ADDR[g]);
      assign mode_hit[g]   = (REG_ADDR == chan_div_pkg::MODE_ADDR[g]);
      assign pwr_hit[g]    = (REG_ADDR == chan_div_pkg::PWR_ADDR[g]);
      assign sync_obey[g]  = SYNC_REQ && !s_q.ign[g];
      assign sync_force[g] = SYNC_REQ && s_q.ign[g];

      // Driver outputs
      assign DIV_OUT[g]      = s_q.out[g];
      assign DUTY_FIX_DIS[g] = s_q.duty_dis[g];
      assign DRV_PD[g*chan_div_pkg::PAIRS +: chan_div_pkg::PAIRS] = {chan_div_pkg::PAIRS{s_q.pd[g]}};
   end

endmodule

// ---- include/chan_div_pkg.sv ----
//******************************************************************************
// Purpose: Constants for the channel divider block (divider 2 and divider 3)
// Assumes: Register port from the serial control port decoder, 8-bit data
// Notes:   Function
//******************************************************************************
package chan_div_pkg;
   localparam int            NCH      = 2;
   localparam int            AW       = 10;
   localparam int            DW       = 8;
   // Register addresses, index 0 is divider 2, index 1 is divider 3
   localparam logic [AW-1:0] CNT_ADDR [NCH] = '{10'h196, 10'h199};
   localparam logic [AW-1:0] MODE_ADDR[NCH] = '{10'h197, 10'h19A};
   localparam logic [AW-1:0] PWR_ADDR [NCH] = '{10'h198, 10'h19B};
   // Count register reset values {low, high}
   localparam logic [DW-1:0] CNT_RST  [NCH] = '{8'h11, 8'h00};
   // Field positions
   localparam int            LOW_LSB  = 4;
   localparam int            HIGH_LSB = 0;
   localparam int            CNT_W    = 4;
   localparam int            BYP_BIT  = 7;
   localparam int            IGN_BIT  = 6;
   localparam int            FRC_BIT  = 5;
   localparam int            STH_BIT  = 4;
   localparam int            PH_LSB   = 0;
   localparam int            PD_BIT   = 2;
   localparam int            DUTY_BIT = 0;
   localparam int            PAIRS    = 3;
   localparam logic [3:0]    PH_RST   = 4'h0;
   localparam logic [3:0]    CNT_ZERO = 4'h0;
   localparam logic [3:0]    CNT_ONE  = 4'h1;
endpackage

// ---- testbench/chan_div_properties.sv ----
// Purpose: Port assertions for the channel dividers
// Assumes: Divider 2 mode register shadowed from writes
// Notes:   Bound to every chan_div
`timescale 1ns/10ps
module chan_div_properties #(parameter int NCH = chan_div_pkg::NCH) (
   // Clock, reset and register port
   input wire logic             CLK, SRST, REG_WE,
   input wire logic [9:0]       REG_ADDR,
   input wire logic [7:0]       REG_WDATA, REG_RDATA,
   // Clock path and driver control
   input wire logic             DIV_IN, SYNC_REQ,
   input wire logic [NCH-1:0]   DIV_OUT, DUTY_FIX_DIS,
   input wire logic [NCH*3-1:0] DRV_PD
);
   logic [7:0] mode_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   always_ff @(posedge CLK) begin
      if (SRST)
         mode_q <= 8'h00;
      else if (REG_WE && REG_ADDR == 10'h197)
         mode_q <= REG_WDATA;
   end
   a_reset_quiet: assert property (disable iff (1'b0) SRST |=> DIV_OUT == '0 && DRV_PD == '0)
      else $error("reset");
   a_mode_read: assert property (REG_ADDR == 10'h197 |=> REG_RDATA == $past(mode_q)) else $error("read");
   a_pd_two: assert property (REG_WE && REG_ADDR == 10'h198 |=> DRV_PD[2:0] == {3{$past(REG_WDATA[2])}})
      else $error("pd2");
   a_pd_three: assert property (REG_WE && REG_ADDR == 10'h19B |=> DRV_PD[5:3] == {3{$past(REG_WDATA[2])}})
      else $error("pd3");
   a_duty_three: assert property (REG_WE && REG_ADDR == 10'h19B |=> DUTY_FIX_DIS[1] == $past(REG_WDATA[0]))
      else $error("duty");
   a_bypass_copy: assert property (mode_q[7] |=> DIV_OUT[0] == $past(DIV_IN)) else $error("bypass");
   a_sync_hold: assert property (SYNC_REQ && mode_q[7:6] == 2'h0 |=> DIV_OUT[0] == $past(mode_q[4]))
      else $error("hold");
   a_force_level: assert property (SYNC_REQ && mode_q[7:6] == 2'h1 |=> DIV_OUT[0] == $past(mode_q[5]))
      else $error("force");
   c_bypass: cover property (mode_q[7]);
   c_force: cover property (SYNC_REQ && mode_q[6]);
   c_hold: cover property (SYNC_REQ && !mode_q[6]);
endmodule
bind chan_div chan_div_properties #(.NCH(NCH)) u_chan_div_properties (.CLK, .SRST, .REG_WE, .REG_ADDR,
   .REG_WDATA, .REG_RDATA, .DIV_IN, .SYNC_REQ, .DIV_OUT, .DUTY_FIX_DIS, .DRV_PD);

// ---- testbench/clock_load.sv ----
// Purpose: Downstream load measuring phase lengths
// Assumes: Level sampled on each rising edge
// Notes:   Lengths in CLK cycles
`timescale 1ns/10ps
module clock_load (
   // Clock, level and last phase lengths
   input wire logic CLK,
   input wire logic lvl,
   output int       hi_len,
   output int       lo_len
);
   int run;
   bit prev;
   always @(posedge CLK) begin
      if (lvl != prev) begin
         if (prev) hi_len <= run;
         else lo_len <= run;
         run <= 1;
      end else run <= run + 1;
      prev <= lvl;
   end
endmodule

// ---- testbench/tb_chan_div.sv ----
// Purpose: Self-checking bench for the channel dividers
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Loads measure phase lengths
`timescale 1ns/10ps
module tb_chan_div;
   logic        CLK, SRST, REG_WE, DIV_IN, SYNC_REQ;
   logic [9:0]  REG_ADDR;
   logic [7:0]  REG_WDATA, REG_RDATA;
   logic [1:0]  DIV_OUT, DUTY_FIX_DIS;
   logic [5:0]  DRV_PD;
   logic [31:0] rnd = 32'hD03BDA7F;
   int          fail_count, total_checks, hl2, ll2, hl3, ll3;
   chan_div u_chan_div (.CLK, .SRST, .REG_ADDR, .REG_WE, .REG_WDATA, .REG_RDATA, .DIV_IN, .SYNC_REQ,
      .DIV_OUT, .DRV_PD, .DUTY_FIX_DIS);
   clock_load u_clock_load_2 (.CLK, .lvl(DIV_OUT[0]), .hi_len(hl2), .lo_len(ll2));
   clock_load u_clock_load_3 (.CLK, .lvl(DIV_OUT[1]), .hi_len(hl3), .lo_len(ll3));
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: %h not %h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      {REG_ADDR, REG_WDATA, REG_WE} = {a, d, 1'b1};
      tick(1);
      REG_WE = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      REG_ADDR = a;
      tick(1);
      chk(REG_RDATA, e);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      #100000;
      fail_count++;
      conclude();
   end
   initial begin
      {SRST, REG_WE, DIV_IN, SYNC_REQ, REG_ADDR, REG_WDATA} = {4'h8, 18'h0};
      tick(10);
      SRST = 1'b0;
      rd(10'h196, 8'h11);
      rd(10'h199, 8'h00);
      rd(10'h19A, 8'h00);
      repeat (4) begin
         rnd = lfsr(rnd);
         wr(10'h196, rnd[7:0]);
         wr(10'h199, rnd[15:8]);
         tick(80);
         chk(8'(hl2), 8'(rnd[3:0]) + 8'h01);
         chk(8'(ll2), 8'(rnd[7:4]) + 8'h01);
         chk(8'(hl3 + ll3), 8'(rnd[11:8]) + 8'(rnd[15:12]) + 8'h02);
      end
      wr(10'h197, 8'hA0);
      repeat (8) begin
         rnd = lfsr(rnd);
         DIV_IN = rnd[0];
         tick(1);
         chk({7'h0, DIV_OUT[0]}, {7'h0, rnd[0]});
      end
      SYNC_REQ = 1'b1;
      wr(10'h197, 8'h60);
      chk({7'h0, DIV_OUT[0]}, 8'h01);
      wr(10'h197, 8'h40);
      chk({7'h0, DIV_OUT[0]}, 8'h00);
      wr(10'h197, 8'h13);
      chk({7'h0, DIV_OUT[0]}, 8'h01);
      SYNC_REQ = 1'b0;
      repeat (3) begin
         tick(1);
         chk({7'h0, DIV_OUT[0]}, 8'h01);
      end
      wr(10'h198, 8'hFF);
      wr(10'h19B, 8'h04);
      chk({2'h0, DRV_PD}, 8'h3F);
      chk({6'h0, DUTY_FIX_DIS}, 8'h01);
      rd(10'h198, 8'h05);
      wr(10'h19C, 8'hFF);
      rd(10'h19C, 8'h00);
      conclude();
   end
endmodule
